// ===== rtl/osdpm_defines.vh
`ifndef OSDPM_DEFINES_VH
`define OSDPM_DEFINES_VH
// Host address map.
`define OSDPM_ROM_TOP        16'h3FFF
`define OSDPM_RAM_BASE       16'h8000
`define OSDPM_RAM_TOP        16'h81FF
`define OSDPM_FRAME_CTRL1    16'h8400
`define OSDPM_FONT_ACCESS    16'h8402
// Reset values.
`define OSDPM_FRAME_CTRL1_RST 8'h98
`define OSDPM_FONT_ACCESS_RST 8'h00
// Field positions.
`define OSDPM_FC1_CLEAR_BIT  3
`define OSDPM_FA_PLANE_BIT   0
`define OSDPM_FA_ATTR_BIT    1
// Page memory geometry.
`define OSDPM_RAM_DEPTH      512
`define OSDPM_RAM_AW         9
// Code values.
`define OSDPM_SCREEN_END     9'h000
`define OSDPM_LINE_END       9'h001
`define OSDPM_FIRST_GLYPH    8'h02
`define OSDPM_FOUR_COLOR_MIN 8'hC0
`define OSDPM_ROW_WIDTH      12
`endif

// ===== rtl/osdpm_page_access.v
`timescale 1ns/100ps
`include "osdpm_defines.vh"

module osdpm_page_access (
  input  wire        core_clk,      // System clock.
  input  wire        srst,          // Synchronous reset, active high.
  input  wire [7:0]  hostByte,      // Byte from the serial port.
  input  wire        addrLoStb,     // Low address byte strobe.
  input  wire        addrHiStb,     // High address byte strobe.
  input  wire        wrStb,         // Data write strobe.
  input  wire        rdStb,         // Data read strobe.
  input  wire [7:0]  fontByte,      // Font ROM data at fontAddr.
  input  wire        dispReq,       // Display fetch strobe.
  input  wire [8:0]  dispAddr,      // Display fetch index.
  input  wire        lineStart,     // Fetch is first code of a line.
  output reg  [7:0]  rdData,        // Read data to the serial port.
  output reg         rdValid,       // Read data valid pulse.
  output reg  [13:0] fontAddr,      // Font ROM byte address.
  output reg         fontPlane,     // Font ROM plane select for the pending read.
  output reg  [7:0]  glyphCode,     // Displayed glyph code.
  output reg  [3:0]  attributeIndex, // Attribute table index.
  output reg         fourColorTable, // Index targets four-color table.
  output reg         glyphValid,    // Fetched code is a glyph.
  output reg         lineEndCode,   // Fetched code ends a line.
  output reg         screenEndCode, // Fetched code ends the screen.
  output reg         blankRowsValid, // Fetched code is a blank rows code.
  output reg  [3:0]  blankRowsCount, // Number of blank pixel rows.
  output reg         clearBusy      // Page clear in progress.
);

  reg [15:0] addr_r;
  reg [7:0]  frameCtrl_r;
  reg [7:0]  fontAcc_r;
  reg [7:0]  codeMem   [0:`OSDPM_RAM_DEPTH-1];
  reg [3:0]  attrMem   [0:`OSDPM_RAM_DEPTH-1];
  reg [3:0]  lastAttr_r;
  reg [8:0]  clrIdx_r;
  reg        rdPend_r;
  reg        rdPend2_r;
  reg [15:0] rdAddr_r;

  wire inRam  = (addr_r >= `OSDPM_RAM_BASE) && (addr_r <= `OSDPM_RAM_TOP);
  wire inRom  = (addr_r <= `OSDPM_ROM_TOP);
  wire [8:0] ramIdx = addr_r[8:0];
  wire [8:0] dispCode = {1'b0, codeMem[dispAddr]};

  // Address register: two bytes low first, then auto-increment after each data byte.
  always @(posedge core_clk) begin
    if (srst) begin
      addr_r <= 16'h0000;
    end else if (addrLoStb) begin
      addr_r <= {addr_r[15:8], hostByte};
    end else if (addrHiStb) begin
      addr_r <= {hostByte, addr_r[7:0]};
    end else if (rdStb || wrStb) begin
      addr_r <= addr_r + 16'h0001;
    end
  end

  // Control registers; the clear bit self-restores once the sweep completes.
  always @(posedge core_clk) begin
    if (srst) begin
      frameCtrl_r <= `OSDPM_FRAME_CTRL1_RST;
      fontAcc_r   <= `OSDPM_FONT_ACCESS_RST;
    end else begin
      if (wrStb && addr_r == `OSDPM_FRAME_CTRL1) begin
        frameCtrl_r <= hostByte;
      end else if (clearBusy && clrIdx_r == 9'h1FF) begin
        frameCtrl_r[`OSDPM_FC1_CLEAR_BIT] <= 1'b1;
      end
      if (wrStb && addr_r == `OSDPM_FONT_ACCESS) begin
        fontAcc_r <= {6'h00, hostByte[1:0]};
      end
    end
  end

  // Clear sweep walks every location once; it takes 512 cycles, not one.
  always @(posedge core_clk) begin
    if (srst) begin
      clearBusy <= 1'b0;
      clrIdx_r  <= 9'h000;
    end else if (wrStb && addr_r == `OSDPM_FRAME_CTRL1 && !hostByte[`OSDPM_FC1_CLEAR_BIT]) begin
      clearBusy <= 1'b1;
      clrIdx_r  <= 9'h000;
    end else if (clearBusy) begin
      clrIdx_r  <= clrIdx_r + 9'h001;
      clearBusy <= (clrIdx_r != 9'h1FF);
    end
  end

  // Page memory writes: with the attribute bit clear a byte is one code and takes the last attribute; with it set the low four bits of the byte are the attribute.
  always @(posedge core_clk) begin
    if (srst) begin
      lastAttr_r <= 4'h0;
    end else if (clearBusy) begin
      codeMem[clrIdx_r] <= 8'h00;
      attrMem[clrIdx_r] <= 4'h0;
    end else if (wrStb && inRam) begin
      if (fontAcc_r[`OSDPM_FA_ATTR_BIT]) begin
        attrMem[ramIdx] <= hostByte[3:0];
        lastAttr_r      <= hostByte[3:0];
      end else begin
        codeMem[ramIdx] <= hostByte;
        attrMem[ramIdx] <= lastAttr_r;
      end
    end
  end
  // Writes into font space fall through with no storage effect.

  // Font address and plane out together; the ROM answers one cycle later.
  // The plane travels with the address so a later register write cannot retarget it.
  always @(posedge core_clk) begin
    if (srst) begin
      fontAddr  <= 14'h0000;
      fontPlane <= 1'b0;
    end else if (rdStb && inRom) begin
      fontAddr  <= addr_r[13:0];
      fontPlane <= fontAcc_r[`OSDPM_FA_PLANE_BIT];
    end
  end

  // Read pipeline: two stages so the ROM byte is settled before capture.
  always @(posedge core_clk) begin
    if (srst) begin
      rdPend_r  <= 1'b0;
      rdPend2_r <= 1'b0;
      rdAddr_r  <= 16'h0000;
      rdData    <= 8'h00;
      rdValid   <= 1'b0;
    end else begin
      rdPend_r  <= rdStb;
      rdPend2_r <= rdPend_r;
      if (rdStb) begin
        rdAddr_r <= addr_r;
      end
      rdValid <= rdPend2_r;
      if (rdPend2_r) begin
        if (rdAddr_r <= `OSDPM_ROM_TOP) begin
          // Odd ROM addresses return only the low nibble of the font byte; even addresses return the whole byte.
          if (rdAddr_r[0]) begin
            rdData <= {4'h0, fontByte[3:0]};
          end else begin
            rdData <= fontByte;
          end
        end else if (rdAddr_r >= `OSDPM_RAM_BASE && rdAddr_r <= `OSDPM_RAM_TOP) begin
          if (fontAcc_r[`OSDPM_FA_ATTR_BIT]) begin
            rdData <= {4'h0, attrMem[rdAddr_r[8:0]]};
          end else begin
            rdData <= codeMem[rdAddr_r[8:0]];
          end
        end else if (rdAddr_r == `OSDPM_FRAME_CTRL1) begin
          rdData <= frameCtrl_r;
        end else if (rdAddr_r == `OSDPM_FONT_ACCESS) begin
          rdData <= fontAcc_r;
        end else begin
          rdData <= 8'h00;
        end
      end
    end
  end

  // Display decode: classify the fetched code for the generator.
  always @(posedge core_clk) begin
    if (srst) begin
      glyphCode      <= 8'h00;
      attributeIndex <= 4'h0;
      fourColorTable <= 1'b0;
      glyphValid     <= 1'b0;
      lineEndCode    <= 1'b0;
      screenEndCode  <= 1'b0;
      blankRowsValid <= 1'b0;
      blankRowsCount <= 4'h0;
    end else begin
      glyphValid     <= 1'b0;
      lineEndCode    <= 1'b0;
      screenEndCode  <= 1'b0;
      blankRowsValid <= 1'b0;
      if (dispReq) begin
        glyphCode      <= dispCode[7:0];
        attributeIndex <= attrMem[dispAddr];
        if (lineStart) begin
          blankRowsValid <= 1'b1;
          blankRowsCount <= dispCode[3:0];
          fourColorTable <= 1'b0;
        end else if (dispCode == `OSDPM_SCREEN_END) begin
          screenEndCode  <= 1'b1;
        end else if (dispCode == `OSDPM_LINE_END) begin
          lineEndCode    <= 1'b1;
        end else if (dispCode[7:0] >= `OSDPM_FIRST_GLYPH) begin
          glyphValid     <= 1'b1;
          fourColorTable <= (dispCode[7:0] >= `OSDPM_FOUR_COLOR_MIN);
        end
      end
    end
  end

endmodule

// ===== testbench/osdpm_asserts.sv
`timescale 1ns/100ps
module osdpm_asserts (
  input wire       core_clk,       // Clock.
  input wire       srst,           // Reset.
  input wire       rdStb,          // Read strobe.
  input wire       rdValid,        // Read data valid.
  input wire       dispReq,        // Fetch strobe.
  input wire       lineStart,      // First code of line.
  input wire [7:0] glyphCode,      // Fetched glyph.
  input wire       fourColorTable, // Table select.
  input wire       glyphValid,     // Glyph pulse.
  input wire       lineEndCode,    // Line end pulse.
  input wire       screenEndCode,  // Screen end pulse.
  input wire       blankRowsValid  // Blank rows pulse.
);
  wire anyCls = glyphValid | lineEndCode | screenEndCode | blankRowsValid;
  // One domain, so the clock and the reset are given once here.
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_read_latency: assert property (rdStb |-> ##3 rdValid) else $error("late read");
  a_read_cause: assert property (rdValid |-> $past(rdStb, 3)) else $error("stray read");
  a_class_onehot: assert property ($onehot0({glyphValid, lineEndCode, screenEndCode,
    blankRowsValid})) else $error("two classes");
  a_class_cause: assert property (anyCls |-> $past(dispReq)) else $error("stray class");
  a_line_skip: assert property (dispReq && lineStart |=> blankRowsValid) else $error("no skip");
  a_skip_table: assert property (blankRowsValid |-> !fourColorTable) else $error("skip tbl");
  a_color_table: assert property (glyphValid |-> fourColorTable == (glyphCode >= 8'hC0))
    else $error("glyph tbl");
  a_glyph_range: assert property (glyphValid |-> glyphCode >= 8'h02) else $error("low glyph");
  c_read: cover property (rdValid);
  c_skip: cover property (blankRowsValid);
  c_line: cover property (lineEndCode);
endmodule
bind osdpm_page_access osdpm_asserts osdpm_asserts_inst (.core_clk(core_clk), .srst(srst),
  .rdStb(rdStb), .rdValid(rdValid), .dispReq(dispReq), .lineStart(lineStart),
  .glyphCode(glyphCode), .fourColorTable(fourColorTable), .glyphValid(glyphValid),
  .lineEndCode(lineEndCode), .screenEndCode(screenEndCode), .blankRowsValid(blankRowsValid));

// ===== testbench/osdpm_rom_model.sv
`timescale 1ns/100ps
module osdpm_rom_model (
  input wire        core_clk, // Clock.
  input wire [13:0] fontAddr, // Byte address.
  input wire        fontPlane, // Plane select.
  output reg [7:0]  fontByte  // Font data.
);
  // Mixing glyph and row bits makes a misplaced address field visible.
  always @(posedge core_clk) begin
    // The plane flips bit 1, which survives in both the whole byte and the low nibble returned for odd addresses.
    fontByte <= fontAddr[7:0] ^ fontAddr[13:6] ^ {6'h00, fontPlane, 1'b0};
  end
endmodule

// ===== testbench/test_osd_page_ram_font_rom_access.sv
`timescale 1ns/100ps
module test_osd_page_ram_font_rom_access;
  reg         core_clk = 1'b0, srst = 1'b1, dispReq = 1'b0, lineStart = 1'b0;
  reg  [3:0]  stb = 4'h0; // Strobes: address low, address high, write, read.
  reg  [7:0]  hostByte = 8'h00;
  reg  [8:0]  dispAddr = 9'h000;
  wire [7:0]  rdData, fontByte, glyphCode;
  wire [13:0] fontAddr;
  wire        fontPlane;
  wire [3:0]  attributeIndex, blankRowsCount;
  wire        rdValid, fourColorTable, glyphValid, lineEndCode, screenEndCode;
  wire        blankRowsValid, clearBusy;
  integer     errors = 0, num_checks = 0;
  osdpm_page_access osdpm_page_access_inst (.core_clk(core_clk), .srst(srst),
    .hostByte(hostByte), .addrLoStb(stb[3]), .addrHiStb(stb[2]), .wrStb(stb[1]),
    .rdStb(stb[0]), .fontByte(fontByte), .dispReq(dispReq), .dispAddr(dispAddr),
    .lineStart(lineStart), .rdData(rdData), .rdValid(rdValid), .fontAddr(fontAddr),
    .fontPlane(fontPlane),
    .glyphCode(glyphCode), .attributeIndex(attributeIndex), .fourColorTable(fourColorTable),
    .glyphValid(glyphValid), .lineEndCode(lineEndCode), .screenEndCode(screenEndCode),
    .blankRowsValid(blankRowsValid), .blankRowsCount(blankRowsCount), .clearBusy(clearBusy));
  osdpm_rom_model osdpm_rom_model_inst (.core_clk(core_clk), .fontAddr(fontAddr),
    .fontPlane(fontPlane), .fontByte(fontByte));
  // Free-running clock of 20 ns.
  always #10 core_clk = ~core_clk;
  task chk(input [7:0] seen, input [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A strobe idles one cycle afterwards, so no signal is driven twice at one edge.
  task st(input [3:0] k, input [7:0] b);
    @(posedge core_clk);
    stb <= k;
    hostByte <= b;
    @(posedge core_clk);
    stb <= 4'h0;
  endtask
  task adr(input [15:0] a);
    st(4'h8, a[7:0]);
    st(4'h4, a[15:8]);
  endtask
  task wr(input [15:0] a, input [7:0] b);
    adr(a);
    st(4'h2, b);
  endtask
  // Read data is looked at on the falling edge where the valid pulse stands.
  task rd(input [7:0] m, input [7:0] exp);
    st(4'h1, 8'h00);
    repeat (3) @(negedge core_clk);
    chk({7'h00, rdValid}, 8'h01);
    chk(rdData & m, exp);
  endtask
  // Class flags are looked at in the one cycle that follows the fetch.
  task disp(input [8:0] a, input ls, input [3:0] cls);
    @(posedge core_clk);
    dispReq <= 1'b1;
    dispAddr <= a;
    lineStart <= ls;
    @(posedge core_clk);
    dispReq <= 1'b0;
    @(negedge core_clk);
    chk({glyphValid, lineEndCode, screenEndCode, blankRowsValid}, cls);
  endtask
  task t_regs;
    integer n;
    adr(16'h8400);
    rd(8'hFF, 8'h98);
    wr(16'h8400, 8'h90);
    for (n = 0; (n < 4 || clearBusy !== 1'b0) && n < 700; n = n + 1) @(posedge core_clk);
    adr(16'h8400);
    rd(8'hFF, 8'h98);
    rd(8'hFF, 8'h00);
    adr(16'h8013);
    rd(8'hFF, 8'h00);
  endtask
  task t_page;
    wr(16'h8402, 8'h02);
    wr(16'h8010, 8'h07);
    wr(16'h8402, 8'h00);
    wr(16'h8010, 8'h41);
    st(4'h2, 8'hC5);
    st(4'h2, 8'h01);
    adr(16'h8010);
    rd(8'hFF, 8'h41);
    rd(8'hFF, 8'hC5);
    wr(16'h8402, 8'h02);
    adr(16'h8010);
    rd(8'h0F, 8'h07);
    rd(8'h0F, 8'h07);
  endtask
  task t_disp;
    disp(9'h010, 1'b1, 4'h1);
    chk(blankRowsCount, 4'h1);
    chk(attributeIndex, 4'h7);
    disp(9'h010, 1'b0, 4'h8);
    chk(glyphCode, 8'h41);
    chk(fourColorTable, 1'b0);
    disp(9'h011, 1'b0, 4'h8);
    chk(fourColorTable, 1'b1);
    disp(9'h012, 1'b0, 4'h4);
    disp(9'h013, 1'b1, 4'h1);
    disp(9'h013, 1'b0, 4'h2);
  endtask
  task t_font;
    wr(16'h8402, 8'h00);
    adr(16'h0042);
    rd(8'hFF, 8'h43);
    wr(16'h0042, 8'h55);
    adr(16'h0042);
    rd(8'hFF, 8'h43);
    adr(16'h3001);
    rd(8'hFF, 8'h01);
    wr(16'h8402, 8'h01);
    adr(16'h3001);
    rd(8'hFF, 8'h03);
  endtask
  task give_verdict;
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    t_regs;
    t_page;
    t_disp;
    t_font;
    give_verdict;
  end
  // The run needs about 700 cycles; this limit is far beyond that.
  initial begin
    #200000;
    errors = errors + 1;
    give_verdict;
  end
endmodule
